/* shared/fuse_pkg.sv */
/*
 * package for the fuse configuration loader: register offsets, fuse field
 * positions, reset values, cycle counts and the fuse image carrier.
 * assumes a 200 MHz system clock and an 8-bit register port.
 */
package fuse_pkg;

    // ------------------------------------------------------------
    // register port offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OSC_CFG_OFS     = 8'h02;
    localparam logic [7:0] TIMER_CFG_OFS   = 8'h04;
    localparam logic [7:0] SYS_CFG0_OFS    = 8'h05;
    localparam logic [7:0] SYS_CFG1_OFS    = 8'h06;
    localparam logic [7:0] APP_END_OFS     = 8'h07;
    localparam logic [7:0] BOOT_END_OFS    = 8'h08;
    localparam logic [7:0] LOCK_OFS        = 8'h0A;
    localparam logic [7:0] ERASE_CTRL_OFS  = 8'h10;
    localparam logic [7:0] LOADER_STAT_OFS = 8'h11;

    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int          OSC_LOCK_BIT   = 7;
    localparam int          EE_PRESERVE_BIT = 0;
    localparam int          ERASE_GO_BIT   = 0;
    localparam logic [1:0]  FREQ_16M       = 2'h1;
    localparam logic [1:0]  FREQ_20M       = 2'h2;
    localparam logic [1:0]  PIN_GPIO       = 2'h0;
    localparam logic [1:0]  PIN_DEBUG      = 2'h1;
    localparam logic [1:0]  PIN_RESET      = 2'h2;
    localparam logic [1:0]  CRC_NONE       = 2'h3;
    localparam logic [7:0]  UNLOCK_KEY     = 8'hC5;
    localparam logic [7:0]  SYS_CFG0_RESET = 8'hC4;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam logic [15:0] ZERO_ADDR      = 16'h0000;
    localparam logic [15:0] FLASH_BYTES    = 16'h2000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          SYS_CLK_MHZ    = 200;
    localparam int          STARTUP_UNIT_MS = 1;
    localparam int          MS_CYCLES      = STARTUP_UNIT_MS * SYS_CLK_MHZ * 1000;
    localparam logic [9:0]  PIN_HOLD_SLOW  = 10'h300;
    localparam logic [23:0] DELAY_ZERO     = 24'h00_0000;

    // ------------------------------------------------------------
    // fuse image as presented by the fuse array
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] osc_cfg;
        logic [7:0] timer_cfg;
        logic [7:0] sys_cfg0;
        logic [7:0] sys_cfg1;
        logic [7:0] app_end;
        logic [7:0] boot_end;
        logic [7:0] lock;
    } fuse_image_s;

    localparam fuse_image_s IMAGE_RESET = '{8'h02, 8'h00, SYS_CFG0_RESET,
                                           8'h07, 8'h00, 8'h00, 8'h00};

    typedef enum logic [1:0] {
        LOAD_FUSES = 2'b00,
        HOLD_START = 2'b01,
        RUNNING    = 2'b10
    } load_state_e;

endpackage : fuse_pkg

/* core/fuse_config_loader.sv */
/*
 * fuse configuration loader: captures the fuse image after reset and
 * drives the clock, timer, crc scan, flash, reset pin and debug port
 * settings from it, with a plain register port for readback.
 * assumes the fuse image is stable and on the system clock at the first edge
 * after RSTN rises, and that POR_N is asserted together with RSTN at power-on only.
 */
`timescale 1ns/1ps

module fuse_config_loader #(
    parameter int MS_CYCLES = fuse_pkg::MS_CYCLES
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RSTN,
    input  wire logic                  POR_N,
    input  wire fuse_pkg::fuse_image_s FUSE_IMAGE,
    input  wire logic [7:0]            CAL16_MAIN,
    input  wire logic [3:0]            CAL16_TEMP,
    input  wire logic [7:0]            CAL20_MAIN,
    input  wire logic [3:0]            CAL20_TEMP,
    input  wire logic                  SLOW_CLK_IN,
    input  wire logic [7:0]            ADDR,
    input  wire logic [7:0]            WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [7:0]            RDATA,
    output logic                       OSC_CALIB_LOCK,
    output logic                       FAST_OSC_20M,
    output logic      [7:0]            OSC_MAIN_CALIBRATION,
    output logic      [3:0]            OSC_TEMP_CALIBRATION,
    output logic      [7:0]            TIMER_FAULT_CONTROL,
    output logic      [1:0]            CRC_SCAN_SOURCE,
    output logic                       SCAN_DISABLED,
    output logic      [1:0]            RESET_PIN_FUNCTION,
    output logic                       RESET_PIN_DRIVE_EN,
    output logic                       DEBUG_BUS_BLOCK,
    output logic                       DEVICE_LOCKED,
    output logic                       ERASE_FLASH,
    output logic                       ERASE_EEPROM,
    output logic      [15:0]           BOOT_END_ADDR,
    output logic      [15:0]           APP_END_ADDR,
    output logic                       CPU_RUN
);

    // ------------------------------------------------------------
    // state and captured fuse image
    // ------------------------------------------------------------
    fuse_pkg::load_state_e state;
    fuse_pkg::load_state_e next_state;
    fuse_pkg::fuse_image_s image;
    logic                  por_pending;
    logic [7:0]            lock_write;
    logic [23:0]           delay_count;
    logic [23:0]           delay_target;
    logic                  slow_meta;
    logic                  slow_sync;
    logic                  slow_prev;
    logic [9:0]            slow_count;
    logic                  loading;
    logic                  locked_now;

    assign loading = (state == fuse_pkg::LOAD_FUSES);
    // any value but the key counts as locked
    assign locked_now = (FUSE_IMAGE.lock != fuse_pkg::UNLOCK_KEY);

    // ------------------------------------------------------------
    // load sequencing
    // ------------------------------------------------------------
    // one capture cycle after release, then the start-up delay
    always_comb begin
        next_state = state;
        unique case (state)
            fuse_pkg::LOAD_FUSES: next_state = fuse_pkg::HOLD_START;
            fuse_pkg::HOLD_START: begin
                if (delay_count >= delay_target) begin
                    next_state = fuse_pkg::RUNNING;
                end
            end
            fuse_pkg::RUNNING:    next_state = fuse_pkg::RUNNING;
            default:              next_state = fuse_pkg::LOAD_FUSES;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= fuse_pkg::LOAD_FUSES;
        end else begin
            state <= next_state;
        end
    end

    // power-on marker survives ordinary resets, cleared once loaded
    always_ff @(posedge SYS_CLK or negedge POR_N) begin
        if (!POR_N) begin
            por_pending <= 1'b1;
        end else if (loading) begin
            por_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // fuse capture
    // ------------------------------------------------------------
    // ports cannot feed an async reset, so capture on the first edge
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            image <= fuse_pkg::IMAGE_RESET;
        end else if (loading) begin
            image <= FUSE_IMAGE;
        end
    end

    // oscillator lock and frequency, applied once per reset
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            OSC_CALIB_LOCK       <= 1'b0;
            FAST_OSC_20M         <= 1'b1;
            OSC_MAIN_CALIBRATION <= fuse_pkg::ZERO_BYTE;
            OSC_TEMP_CALIBRATION <= 4'h0;
        end else if (loading) begin
            OSC_CALIB_LOCK <= FUSE_IMAGE.osc_cfg[fuse_pkg::OSC_LOCK_BIT];
            // reserved codes fall back to 20 MHz
            FAST_OSC_20M   <= (FUSE_IMAGE.osc_cfg[1:0] != fuse_pkg::FREQ_16M);
            if (FUSE_IMAGE.osc_cfg[1:0] == fuse_pkg::FREQ_16M) begin
                OSC_MAIN_CALIBRATION <= CAL16_MAIN;
                OSC_TEMP_CALIBRATION <= CAL16_TEMP;
            end else begin
                OSC_MAIN_CALIBRATION <= CAL20_MAIN;
                OSC_TEMP_CALIBRATION <= CAL20_TEMP;
            end
        end
    end

    // timer defaults sit on the power-on reset only
    always_ff @(posedge SYS_CLK or negedge POR_N) begin
        if (!POR_N) begin
            TIMER_FAULT_CONTROL <= fuse_pkg::ZERO_BYTE;
        end else if (loading && por_pending) begin
            // bits 7:4 pin enables, bits 3:0 default states
            TIMER_FAULT_CONTROL <= FUSE_IMAGE.timer_cfg;
        end
    end

    // scan source, pin function and lock state
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CRC_SCAN_SOURCE    <= fuse_pkg::CRC_NONE;
            SCAN_DISABLED      <= 1'b1;
            RESET_PIN_FUNCTION <= fuse_pkg::PIN_DEBUG;
            DEVICE_LOCKED      <= 1'b1;
            DEBUG_BUS_BLOCK    <= 1'b1;
        end else if (loading) begin
            CRC_SCAN_SOURCE    <= FUSE_IMAGE.sys_cfg0[7:6];
            SCAN_DISABLED      <= (FUSE_IMAGE.sys_cfg0[7:6] == fuse_pkg::CRC_NONE);
            RESET_PIN_FUNCTION <= FUSE_IMAGE.sys_cfg0[3:2];
            DEVICE_LOCKED      <= locked_now;
            // blocked until proven open, so no window after reset
            DEBUG_BUS_BLOCK    <= locked_now;
        end
    end

    // ------------------------------------------------------------
    // flash partitioning
    // ------------------------------------------------------------
    // byte addresses of the section ends; above app end is data
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            BOOT_END_ADDR <= fuse_pkg::FLASH_BYTES;
            APP_END_ADDR  <= fuse_pkg::FLASH_BYTES;
        end else if (loading) begin
            if (FUSE_IMAGE.boot_end == fuse_pkg::ZERO_BYTE) begin
                BOOT_END_ADDR <= fuse_pkg::FLASH_BYTES;
                APP_END_ADDR  <= fuse_pkg::FLASH_BYTES;
            end else begin
                BOOT_END_ADDR <= {FUSE_IMAGE.boot_end, 8'h00};
                if (FUSE_IMAGE.app_end == fuse_pkg::ZERO_BYTE) begin
                    APP_END_ADDR <= fuse_pkg::FLASH_BYTES;
                end else begin
                    // counted from flash start, boot included
                    APP_END_ADDR <= {FUSE_IMAGE.app_end, 8'h00};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // start-up delay
    // ------------------------------------------------------------
    // delay is 0 or 2^(code-1) ms; only a power-on waits
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            delay_target <= fuse_pkg::DELAY_ZERO;
        end else if (loading) begin
            if (!por_pending || FUSE_IMAGE.sys_cfg1[2:0] == 3'h0) begin
                delay_target <= fuse_pkg::DELAY_ZERO;
            end else begin
                delay_target <= 24'(MS_CYCLES) << (FUSE_IMAGE.sys_cfg1[2:0] - 3'h1);
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            delay_count <= fuse_pkg::DELAY_ZERO;
            CPU_RUN     <= 1'b0;
        end else begin
            if (state == fuse_pkg::HOLD_START) begin
                delay_count <= delay_count + 24'h00_0001;
            end
            CPU_RUN <= (next_state == fuse_pkg::RUNNING);
        end
    end

    // ------------------------------------------------------------
    // reset pin driver hold-off
    // ------------------------------------------------------------
    // slow clock is foreign, so two flops before the edge detect
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            slow_meta <= 1'b1;
            slow_sync <= 1'b1;
            slow_prev <= 1'b1; // high, so a clock high at release is no edge
        end else begin
            slow_meta <= SLOW_CLK_IN;
            slow_sync <= slow_meta;
            slow_prev <= slow_sync;
        end
    end

    // counts slow rising edges after every system reset
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            slow_count         <= 10'h000;
            RESET_PIN_DRIVE_EN <= 1'b0;
        end else begin
            if (slow_count != fuse_pkg::PIN_HOLD_SLOW && slow_sync && !slow_prev) begin
                slow_count <= slow_count + 10'h001;
            end
            // driver only after the hold-off and only as gpio
            RESET_PIN_DRIVE_EN <= (slow_count == fuse_pkg::PIN_HOLD_SLOW)
                                && (RESET_PIN_FUNCTION == fuse_pkg::PIN_GPIO)
                                && !loading;
        end
    end

    // ------------------------------------------------------------
    // chip erase
    // ------------------------------------------------------------
    // a locked part never keeps its eeprom, so no secret survives
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ERASE_FLASH  <= 1'b0;
            ERASE_EEPROM <= 1'b0;
        end else begin
            ERASE_FLASH  <= WR && ADDR == fuse_pkg::ERASE_CTRL_OFS
                            && WDATA[fuse_pkg::ERASE_GO_BIT] && !loading;
            ERASE_EEPROM <= WR && ADDR == fuse_pkg::ERASE_CTRL_OFS
                            && WDATA[fuse_pkg::ERASE_GO_BIT] && !loading
                            && (DEVICE_LOCKED
                                || !image.sys_cfg0[fuse_pkg::EE_PRESERVE_BIT]);
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // lock writes are held for the fuse array; effect waits for reset
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            lock_write <= fuse_pkg::ZERO_BYTE;
        end else if (loading) begin
            lock_write <= FUSE_IMAGE.lock;
        end else if (WR && ADDR == fuse_pkg::LOCK_OFS) begin
            lock_write <= WDATA;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= fuse_pkg::ZERO_BYTE;
        end else if (RD) begin
            unique case (ADDR)
                fuse_pkg::OSC_CFG_OFS:     RDATA <= image.osc_cfg;
                fuse_pkg::TIMER_CFG_OFS:   RDATA <= image.timer_cfg;
                fuse_pkg::SYS_CFG0_OFS:    RDATA <= image.sys_cfg0;
                fuse_pkg::SYS_CFG1_OFS:    RDATA <= image.sys_cfg1;
                fuse_pkg::APP_END_OFS:     RDATA <= image.app_end;
                fuse_pkg::BOOT_END_OFS:    RDATA <= image.boot_end;
                fuse_pkg::LOCK_OFS:        RDATA <= lock_write;
                fuse_pkg::LOADER_STAT_OFS: RDATA <= {4'h0, RESET_PIN_DRIVE_EN,
                                                     DEBUG_BUS_BLOCK, DEVICE_LOCKED,
                                                     CPU_RUN};
                default:                   RDATA <= fuse_pkg::ZERO_BYTE;
            endcase
        end else begin
            RDATA <= fuse_pkg::ZERO_BYTE;
        end
    end

endmodule : fuse_config_loader

/* dv/fuse_config_loader_sva.sv */
/*
 * checker for the fuse configuration loader, bound to its top ports.
 * assumes one clock domain; RSTN disables every assertion.
 */
`timescale 1ns/1ps

module fuse_loader_checker #(
    parameter int MS_CYCLES = 10
) (
    input wire logic                  SYS_CLK,
    input wire logic                  RSTN,
    input wire logic                  POR_N,
    input wire fuse_pkg::fuse_image_s FUSE_IMAGE,
    input wire logic [7:0]            ADDR,
    input wire logic [7:0]            WDATA,
    input wire logic                  WR,
    input wire logic                  RD,
    input wire logic [7:0]            RDATA,
    input wire logic                  OSC_CALIB_LOCK,
    input wire logic [7:0]            TIMER_FAULT_CONTROL,
    input wire logic [1:0]            CRC_SCAN_SOURCE,
    input wire logic                  SCAN_DISABLED,
    input wire logic [1:0]            RESET_PIN_FUNCTION,
    input wire logic                  RESET_PIN_DRIVE_EN,
    input wire logic                  DEBUG_BUS_BLOCK,
    input wire logic                  DEVICE_LOCKED,
    input wire logic                  ERASE_FLASH,
    input wire logic                  ERASE_EEPROM,
    input wire logic [15:0]           BOOT_END_ADDR,
    input wire logic                  CPU_RUN
);
    // ----------------------------------------------------------------
    // helpers: load edge and power-on memory
    // ----------------------------------------------------------------
    logic rel;
    logic por_flag;
    logic load;

    // first edge after release is the capture edge
    always_ff @(posedge SYS_CLK or negedge RSTN)
        if (!RSTN) rel <= 1'b0;
        else rel <= 1'b1;
    assign load = RSTN && !rel;

    // kept apart from RSTN so a plain reset is told from power-on
    always_ff @(posedge SYS_CLK or negedge POR_N)
        if (!POR_N) por_flag <= 1'b1;
        else if (load) por_flag <= 1'b0;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    scan_flag_a: assert property (SCAN_DISABLED == (CRC_SCAN_SOURCE == fuse_pkg::CRC_NONE))
        else $error("scan disable flag disagrees with source");
    lock_pair_a: assert property (DEVICE_LOCKED == DEBUG_BUS_BLOCK)
        else $error("debug block differs from lock state");
    lock_key_a: assert property (load |=> DEVICE_LOCKED == ($past(FUSE_IMAGE.lock) != 8'hC5))
        else $error("lock state not from key");
    calib_lock_a: assert property (load |=> OSC_CALIB_LOCK == $past(FUSE_IMAGE.osc_cfg[7]))
        else $error("calibration lock not from fuse bit");
    timer_load_a: assert property (load && por_flag |=> TIMER_FAULT_CONTROL == $past(FUSE_IMAGE.timer_cfg))
        else $error("timer byte not loaded at power-on");
    timer_keep_a: assert property (load && !por_flag |=> $stable(TIMER_FAULT_CONTROL))
        else $error("timer byte changed on plain reset");
    hold_stable_a: assert property (rel && $past(rel) |-> $stable(OSC_CALIB_LOCK)
        && $stable(RESET_PIN_FUNCTION) && $stable(BOOT_END_ADDR))
        else $error("captured value moved after load");
    erase_go_a: assert property (rel && WR && ADDR == fuse_pkg::ERASE_CTRL_OFS && WDATA[0]
        |=> ERASE_FLASH)
        else $error("chip erase not issued");
    erase_pair_a: assert property (ERASE_EEPROM |-> ERASE_FLASH)
        else $error("eeprom erase without chip erase");
    locked_erase_a: assert property (ERASE_FLASH && DEVICE_LOCKED |-> ERASE_EEPROM)
        else $error("locked erase spared eeprom");
    pin_hold_a: assert property (load |=> !RESET_PIN_DRIVE_EN [*8])
        else $error("pin driver enabled too early");
    boot_zero_a: assert property (load && FUSE_IMAGE.boot_end == fuse_pkg::ZERO_BYTE
        |=> BOOT_END_ADDR == fuse_pkg::FLASH_BYTES)
        else $error("zero boot end not whole flash");
    run_fast_a: assert property (load && (!por_flag || FUSE_IMAGE.sys_cfg1[2:0] == 3'h0)
        |=> ##1 CPU_RUN)
        else $error("core held without start-up delay");
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == fuse_pkg::ZERO_BYTE)
        else $error("read data outside read answer");

    cover property (load && por_flag);
    cover property (ERASE_EEPROM);
    cover property ($rose(RESET_PIN_DRIVE_EN));
    cover property ($rose(CPU_RUN));
endmodule : fuse_loader_checker

bind fuse_config_loader fuse_loader_checker #(.MS_CYCLES(MS_CYCLES)) checker_i (
    .SYS_CLK, .RSTN, .POR_N, .FUSE_IMAGE, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .OSC_CALIB_LOCK, .TIMER_FAULT_CONTROL, .CRC_SCAN_SOURCE, .SCAN_DISABLED,
    .RESET_PIN_FUNCTION, .RESET_PIN_DRIVE_EN, .DEBUG_BUS_BLOCK, .DEVICE_LOCKED,
    .ERASE_FLASH, .ERASE_EEPROM, .BOOT_END_ADDR, .CPU_RUN
);

/* dv/fuse_array_model.sv */
/*
 * behavioural fuse array and reset controller for the loader bench.
 * assumes requests are one-cycle pulses on the system clock.
 */
`timescale 1ns/1ps

module fuse_array_model (
    input  wire logic                  SYS_CLK,
    input  wire logic                  por_req,
    input  wire logic                  rst_req,
    input  wire fuse_pkg::fuse_image_s image,
    input  wire logic [23:0]           cal_in,
    output logic                       RSTN = 1'b0,
    output logic                       POR_N = 1'b0,
    output fuse_pkg::fuse_image_s      FUSE_IMAGE = '0,
    output logic [23:0]                cal_out = '0
);
    logic [2:0] cnt    = 3'd7;
    logic       rstn_d = 1'b0;
    logic       hold;

    // four-cycle reset; POR_N released together with RSTN
    always @(posedge SYS_CLK) begin
        if (por_req || rst_req) cnt <= 3'd4;
        else if (cnt != 3'd0) cnt <= cnt - 3'd1;
        RSTN <= !(por_req || rst_req) && cnt <= 3'd1;
        POR_N <= !por_req && (POR_N || cnt <= 3'd1);
        rstn_d <= RSTN;
    end

    // honest only around the load; inverse later so a late capture shows
    assign hold = !RSTN || !rstn_d;
    always @(posedge SYS_CLK) begin
        FUSE_IMAGE <= hold ? image : ~image;
        cal_out <= hold ? cal_in : ~cal_in;
    end
endmodule : fuse_array_model

/* dv/fuse_config_loader_tb.sv */
/*
 * testbench for the fuse configuration loader: power-on sweep, plain reset,
 * register port and pin hold-off.
 * assumes the fuse array model in the same folder; slow clock is sped up.
 */
`timescale 1ns/1ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %0t: got %0h expected %0h", $time, (got), (exp)); end end

module fuse_config_loader_tb;
    localparam int          MS  = 10;
    localparam logic [23:0] CAL = 24'hA53C_96;

    logic SYS_CLK = 1'b0, SLOW_CLK_IN = 1'b0, por_req = 1'b0, rst_req = 1'b0;
    logic RSTN, POR_N, WR = 1'b0, RD = 1'b0, OSC_CALIB_LOCK, FAST_OSC_20M;
    logic SCAN_DISABLED, RESET_PIN_DRIVE_EN, DEBUG_BUS_BLOCK, DEVICE_LOCKED;
    logic ERASE_FLASH, ERASE_EEPROM, CPU_RUN, lk;
    logic [1:0]  CRC_SCAN_SOURCE, RESET_PIN_FUNCTION;
    logic [3:0]  OSC_TEMP_CALIBRATION;
    logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RDATA, OSC_MAIN_CALIBRATION;
    logic [7:0]  TIMER_FAULT_CONTROL;
    logic [15:0] BOOT_END_ADDR, APP_END_ADDR, bend, aend;
    logic [23:0] cal_out;
    fuse_pkg::fuse_image_s image = '0, FUSE_IMAGE, im;
    fuse_pkg::fuse_image_s base [4] = '{56'h0200_C400_0000_C5, 56'h81A5_0000_0004_00,
                                        56'h035A_4900_1004_C5, 56'h80FF_8D00_2001_C4};
    logic [7:0]  ofs [7] = '{fuse_pkg::OSC_CFG_OFS, fuse_pkg::TIMER_CFG_OFS,
        fuse_pkg::SYS_CFG0_OFS, fuse_pkg::SYS_CFG1_OFS, fuse_pkg::APP_END_OFS,
        fuse_pkg::BOOT_END_OFS, fuse_pkg::LOCK_OFS};
    int miscompares = 0, compares = 0, cycles = 0, n, d;

    // slow clock far faster than 32 kHz to keep the 768-count short
    always #2.5 SYS_CLK = ~SYS_CLK;
    always #23.5 SLOW_CLK_IN = ~SLOW_CLK_IN;

    fuse_array_model MODEL (.SYS_CLK, .por_req, .rst_req, .image, .cal_in(CAL),
        .RSTN, .POR_N, .FUSE_IMAGE, .cal_out);

    fuse_config_loader #(.MS_CYCLES(MS)) DUT (.SYS_CLK, .RSTN, .POR_N, .FUSE_IMAGE,
        .CAL16_MAIN(cal_out[23:16]), .CAL16_TEMP(cal_out[15:12]),
        .CAL20_MAIN(cal_out[11:4]), .CAL20_TEMP(cal_out[3:0]), .SLOW_CLK_IN,
        .ADDR, .WDATA, .WR, .RD, .RDATA, .OSC_CALIB_LOCK, .FAST_OSC_20M,
        .OSC_MAIN_CALIBRATION, .OSC_TEMP_CALIBRATION, .TIMER_FAULT_CONTROL,
        .CRC_SCAN_SOURCE, .SCAN_DISABLED, .RESET_PIN_FUNCTION, .RESET_PIN_DRIVE_EN,
        .DEBUG_BUS_BLOCK, .DEVICE_LOCKED, .ERASE_FLASH, .ERASE_EEPROM,
        .BOOT_END_ADDR, .APP_END_ADDR, .CPU_RUN);

    // ----------------------------------------------------------------
    // register port and reset tasks, all entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        @(negedge SYS_CLK);
        `CHK(RDATA, e)
        @(posedge SYS_CLK);
    endtask : expect_rd

    // counts half-cycles-late negedges until the core starts running
    task automatic restart(input logic por, input fuse_pkg::fuse_image_s f);
        image <= f;
        por_req <= por;
        rst_req <= !por;
        @(posedge SYS_CLK);
        por_req <= 1'b0;
        rst_req <= 1'b0;
        n = 0;
        do begin
            @(negedge SYS_CLK);
            n++;
        end while (CPU_RUN !== 1'b1 && n < 1000);
        @(posedge SYS_CLK);
    endtask : restart

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // hang guard, well above the longest expected run
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 12000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        @(posedge SYS_CLK);
        // power-on sweep: every start-up code, four fuse images
        for (int i = 0; i < 8; i++) begin
            im = base[i % 4];
            im.sys_cfg1 = 8'(i);
            d = (i == 0) ? 0 : (MS << (i - 1));
            lk = im.lock != 8'hC5;
            bend = (im.boot_end == 8'h00) ? fuse_pkg::FLASH_BYTES : {im.boot_end, 8'h00};
            aend = (im.boot_end == 8'h00 || im.app_end == 8'h00) ? fuse_pkg::FLASH_BYTES
                                                                 : {im.app_end, 8'h00};
            restart(1'b1, im);
            `CHK(n >= 6 + d && n <= 8 + d, 1'b1)
            `CHK(OSC_CALIB_LOCK, im.osc_cfg[7])
            `CHK(FAST_OSC_20M, im.osc_cfg[1:0] != fuse_pkg::FREQ_16M)
            `CHK({OSC_MAIN_CALIBRATION, OSC_TEMP_CALIBRATION},
                 (im.osc_cfg[1:0] == fuse_pkg::FREQ_16M) ? CAL[23:12] : CAL[11:0])
            `CHK(TIMER_FAULT_CONTROL, im.timer_cfg)
            `CHK({CRC_SCAN_SOURCE, SCAN_DISABLED},
                 {im.sys_cfg0[7:6], im.sys_cfg0[7:6] == fuse_pkg::CRC_NONE})
            `CHK(RESET_PIN_FUNCTION, im.sys_cfg0[3:2])
            `CHK(RESET_PIN_DRIVE_EN, 1'b0)
            `CHK({DEVICE_LOCKED, DEBUG_BUS_BLOCK}, {lk, lk})
            `CHK({BOOT_END_ADDR, APP_END_ADDR}, {bend, aend})
            // fuse lines are inverted by now, so reads show the held copy
            for (int j = 0; j < 7; j++) expect_rd(ofs[j], im[55 - 8 * j -: 8]);
            expect_rd(8'h03, 8'h00);
            expect_rd(fuse_pkg::LOADER_STAT_OFS, {5'h00, lk, lk, 1'b1});
            wr(fuse_pkg::SYS_CFG0_OFS, ~im.sys_cfg0);
            expect_rd(fuse_pkg::SYS_CFG0_OFS, im.sys_cfg0);
            wr(fuse_pkg::LOCK_OFS, 8'h3C);
            expect_rd(fuse_pkg::LOCK_OFS, 8'h3C);
            wr(fuse_pkg::ERASE_CTRL_OFS, 8'h01);
            @(negedge SYS_CLK);
            `CHK({ERASE_FLASH, ERASE_EEPROM}, {1'b1, lk | !im.sys_cfg0[0]})
            @(posedge SYS_CLK);
        end
        // plain reset: timer byte kept, rest reloaded, gpio pin held off
        im = base[1];
        im.sys_cfg1 = 8'h07;
        restart(1'b0, im);
        `CHK(TIMER_FAULT_CONTROL, 8'hFF)
        `CHK(OSC_CALIB_LOCK, 1'b1)
        `CHK(n >= 6 && n <= 8, 1'b1)
        repeat (760) @(posedge SLOW_CLK_IN);
        @(negedge SYS_CLK);
        `CHK(RESET_PIN_DRIVE_EN, 1'b0)
        repeat (12) @(posedge SLOW_CLK_IN); // pin touched only after hold-off
        @(negedge SYS_CLK);
        `CHK(RESET_PIN_DRIVE_EN, 1'b1)
        report_and_stop();
    end
endmodule : fuse_config_loader_tb
